// [bit_sync.sv]
// two flip-flop synchroniser for levels
`timescale 1ns/1ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_t;

   sync_t s_reg;
   sync_t s_next;

   always_comb begin
      s_next.s1 = d;
      s_next.s2 = s_reg.s1;
   end

   always_ff @(posedge clk) begin
      s_reg <= s_next;
   end

   assign q = s_reg.s2;

endmodule

// [cdc_fifo.sv]
// dual clock fifo with gray coded pointers
`timescale 1ns/1ps
module cdc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic wr_clk,
   input wire logic wr_rst,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_clk,
   input wire logic rd_rst,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] bin;
      logic [AW:0] gray;
   } wside_t;

   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
   } rside_t;

   wside_t w_reg;
   wside_t w_next;
   rside_t r_reg;
   rside_t r_next;
   logic [AW:0] rgray_w;
   logic [AW:0] wgray_r;
   logic [AW:0] wbin_inc;
   logic [AW:0] rbin_inc;

   bit_sync #(.WIDTH(AW + 1)) u_rptr_sync (.clk(wr_clk), .d(r_reg.gray), .q(rgray_w));
   bit_sync #(.WIDTH(AW + 1)) u_wptr_sync (.clk(rd_clk), .d(w_reg.gray), .q(wgray_r));

   assign wr_ready = w_reg.gray != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]};
   assign rd_valid = r_reg.gray != wgray_r;
   assign rd_data = w_reg.mem[r_reg.bin[AW-1:0]];
   assign wbin_inc = w_reg.bin + (AW + 1)'(1);
   assign rbin_inc = r_reg.bin + (AW + 1)'(1);

   // ---------------------------------------------
   // write side
   // ---------------------------------------------
   always_comb begin
      w_next = w_reg;
      if (wr_valid && wr_ready) begin
         w_next.mem[w_reg.bin[AW-1:0]] = wr_data;
         w_next.bin = wbin_inc;
         w_next.gray = wbin_inc ^ (wbin_inc >> 1);
      end
   end

   always_ff @(posedge wr_clk) begin
      if (wr_rst) begin
         w_reg <= '0;
      end else begin
         w_reg <= w_next;
      end
   end

   // ---------------------------------------------
   // read side
   // ---------------------------------------------
   always_comb begin
      r_next = r_reg;
      if (rd_valid && rd_ready) begin
         r_next.bin = rbin_inc;
         r_next.gray = rbin_inc ^ (rbin_inc >> 1);
      end
   end

   always_ff @(posedge rd_clk) begin
      if (rd_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

endmodule

// [i2c_gc_pkg.sv]
// shared constants and types of the general call receiver
package i2c_gc_pkg;

   // ---------------------------------------------
   // data path
   // ---------------------------------------------
   localparam int DATA_W = 8;
   localparam int FIFO_W = 9;
   localparam int FIFO_DEPTH = 8;
   localparam int ADDR_W = 7;
   localparam int TAG_POS = 8;

   // ---------------------------------------------
   // protocol values
   // ---------------------------------------------
   localparam logic [7:0] GC_ADDR = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;

   // ---------------------------------------------
   // link state machine and host side registers
   // ---------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ADDR = 4'h2,
      ST_ACK = 4'h4,
      ST_DATA = 4'h8
   } link_state_t;

   typedef struct packed {
      link_state_t st;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic gc;
      logic sda_oe;
      logic scl_oe;
      logic sda_out;
      logic scl_out;
      logic scl_d;
      logic sda_d;
   } link_t;

   typedef struct packed {
      logic [7:0] bdr;
      logic ready;
      logic flag;
      logic irq;
      logic abort;
   } host_t;

endpackage

// [i2c_general_call_power_modes.sv]
// receive-only bus slave with general call and power modes
//
// How it works
// (RULE1) master sends address zero, then data
// (RULE2) enable set: acknowledge broadcast, keep receiving
// (RULE3) broadcast: slave only receives, never sends
// (RULE4) broadcast match sets addressed-as-slave flag
// (RULE5) data register shows received address byte
// (RULE6) first broadcast data byte passed on untouched
// (RULE7) each received byte readable from data register
// (RULE8) wait mode: run on or power down
// (RULE9) low-power wait aborts transfer in progress
// (RULE10) stop mode: inactive, registers kept
// (RULE11) all requests share one interrupt line
// (RULE12) enable clear: broadcast not acknowledged, ignored
`timescale 1ns/1ps
module i2c_general_call_power_modes (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_link,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic general_call_enable,
   input wire logic [i2c_gc_pkg::ADDR_W-1:0] own_address,
   input wire logic wait_mode,
   input wire logic wait_power_down,
   input wire logic stop_mode,
   input wire logic data_read,
   input wire logic flag_clear,
   output logic [i2c_gc_pkg::DATA_W-1:0] bus_data_register,
   output logic data_ready,
   output logic addressed_as_slave_flag,
   output logic irq
);

   // ---------------------------------------------
   // crossings
   // ---------------------------------------------
   i2c_gc_pkg::link_t l_reg;
   i2c_gc_pkg::link_t l_next;
   i2c_gc_pkg::host_t h_reg;
   i2c_gc_pkg::host_t h_next;
   logic rst_link;
   logic scl_s;
   logic sda_s;
   logic abort_l;
   logic general_call_enable_l;
   logic [i2c_gc_pkg::ADDR_W-1:0] own_l;
   logic wr_valid;
   logic wr_ready;
   logic [i2c_gc_pkg::FIFO_W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [i2c_gc_pkg::FIFO_W-1:0] rd_data;

   bit_sync #(.WIDTH(1)) u_rst_sync (.clk(clk_link), .d(sys_rst), .q(rst_link));
   bit_sync #(.WIDTH(2)) u_pin_sync (.clk(clk_link), .d({scl_in, sda_in}), .q({scl_s, sda_s}));
   bit_sync #(.WIDTH(i2c_gc_pkg::ADDR_W + 2)) u_cfg_sync (
      .clk(clk_link),
      .d({h_reg.abort, general_call_enable, own_address}),
      .q({abort_l, general_call_enable_l, own_l})
   );

   cdc_fifo #(.WIDTH(i2c_gc_pkg::FIFO_W), .DEPTH(i2c_gc_pkg::FIFO_DEPTH)) u_fifo (
      .wr_clk(clk_link),
      .wr_rst(rst_link),
      .wr_valid(wr_valid),
      .wr_ready(wr_ready),
      .wr_data(wr_data),
      .rd_clk(clk_sys),
      .rd_rst(sys_rst),
      .rd_valid(rd_valid),
      .rd_ready(rd_ready),
      .rd_data(rd_data)
   );

   // ---------------------------------------------
   // link side receiver
   // ---------------------------------------------
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic match_gc;
   logic match_own;
   logic byte_done;

   assign scl_rise = scl_s && !l_reg.scl_d;
   assign scl_fall = !scl_s && l_reg.scl_d;
   assign start_c = scl_s && l_reg.scl_d && l_reg.sda_d && !sda_s;
   assign stop_c = scl_s && l_reg.scl_d && !l_reg.sda_d && sda_s;
   assign match_gc = (l_reg.shift == i2c_gc_pkg::GC_ADDR) && general_call_enable_l;
   assign match_own = (l_reg.shift[7:1] == own_l) && !l_reg.shift[0];
   assign byte_done = l_reg.cnt == i2c_gc_pkg::BITS_PER_BYTE;
   assign wr_data = {l_reg.st == i2c_gc_pkg::ST_ADDR, l_reg.shift};

   always_comb begin
      l_next = l_reg;
      wr_valid = 1'b0;
      l_next.scl_d = scl_s;
      l_next.sda_d = sda_s;
      l_next.sda_out = 1'b0;
      l_next.scl_out = 1'b0;
      if (abort_l) begin
         // power down or stop: drop whatever is running
         l_next.st = i2c_gc_pkg::ST_IDLE; // RULE9 RULE10
         l_next.sda_oe = 1'b0;
         l_next.scl_oe = 1'b0;
         l_next.cnt = i2c_gc_pkg::CNT_ZERO;
      end else if (stop_c) begin
         l_next.st = i2c_gc_pkg::ST_IDLE; // RULE2
         l_next.sda_oe = 1'b0;
         l_next.scl_oe = 1'b0;
      end else if (start_c) begin
         l_next.st = i2c_gc_pkg::ST_ADDR; // RULE2
         l_next.cnt = i2c_gc_pkg::CNT_ZERO;
         l_next.gc = 1'b0;
         l_next.sda_oe = 1'b0;
         l_next.scl_oe = 1'b0;
      end else begin
         unique case (l_reg.st)
            i2c_gc_pkg::ST_IDLE: begin
               l_next.sda_oe = 1'b0;
            end
            i2c_gc_pkg::ST_ADDR, i2c_gc_pkg::ST_DATA: begin
               if (l_reg.st == i2c_gc_pkg::ST_DATA && l_reg.gc && !general_call_enable_l) begin
                  l_next.st = i2c_gc_pkg::ST_IDLE; // RULE2
                  l_next.scl_oe = 1'b0;
               end else if (!byte_done && scl_rise) begin
                  l_next.shift = {l_reg.shift[6:0], sda_s};
                  l_next.cnt = l_reg.cnt + i2c_gc_pkg::CNT_ONE;
               end else if (byte_done && (scl_fall || l_reg.scl_oe)) begin
                  if (l_reg.st == i2c_gc_pkg::ST_ADDR && !match_gc && !match_own) begin
                     l_next.st = i2c_gc_pkg::ST_IDLE; // RULE12
                  end else if (wr_ready) begin
                     wr_valid = 1'b1; // RULE5 RULE6 RULE7
                     l_next.sda_oe = 1'b1; // RULE2
                     l_next.scl_oe = 1'b0;
                     l_next.st = i2c_gc_pkg::ST_ACK;
                     if (l_reg.st == i2c_gc_pkg::ST_ADDR) begin
                        l_next.gc = match_gc;
                     end
                  end else begin
                     l_next.scl_oe = 1'b1;
                  end
               end
            end
            i2c_gc_pkg::ST_ACK: begin
               if (scl_fall) begin
                  l_next.sda_oe = 1'b0; // RULE3
                  l_next.cnt = i2c_gc_pkg::CNT_ZERO;
                  l_next.st = i2c_gc_pkg::ST_DATA;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_link) begin
      if (rst_link) begin
         l_reg <= '0;
         l_reg.st <= i2c_gc_pkg::ST_IDLE;
         l_reg.scl_d <= 1'b1;
         l_reg.sda_d <= 1'b1;
      end else begin
         l_reg <= l_next;
      end
   end

   assign scl_out = l_reg.scl_out;
   assign scl_oe = l_reg.scl_oe;
   assign sda_out = l_reg.sda_out;
   assign sda_oe = l_reg.sda_oe;

   // ---------------------------------------------
   // system side data register and flags
   // ---------------------------------------------
   assign rd_ready = !stop_mode && (!h_reg.ready || data_read);

   always_comb begin
      h_next = h_reg;
      h_next.abort = stop_mode || (wait_mode && wait_power_down); // RULE8 RULE9 RULE10
      if (!stop_mode) begin
         if (flag_clear) begin
            h_next.flag = 1'b0;
         end
         if (data_read) begin
            h_next.ready = 1'b0;
         end
         if (rd_valid && rd_ready) begin
            h_next.bdr = rd_data[i2c_gc_pkg::DATA_W-1:0]; // RULE5 RULE7
            h_next.ready = 1'b1;
            if (rd_data[i2c_gc_pkg::TAG_POS]) begin
               h_next.flag = 1'b1; // RULE4
            end
         end
      end
      h_next.irq = h_next.ready || h_next.flag; // RULE11
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         h_reg <= '0;
      end else begin
         h_reg <= h_next;
      end
   end

   assign bus_data_register = h_reg.bdr;
   assign data_ready = h_reg.ready;
   assign addressed_as_slave_flag = h_reg.flag;
   assign irq = h_reg.irq;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   gc_nack_a: assert property ( // RULE12
      @(posedge clk_link) disable iff (rst_link)
      (l_reg.st == i2c_gc_pkg::ST_ADDR && byte_done && scl_fall && !abort_l
       && l_reg.shift == i2c_gc_pkg::GC_ADDR && !general_call_enable_l && !match_own)
      |=> (l_reg.st == i2c_gc_pkg::ST_IDLE && !sda_oe)
   ) else $error("broadcast acknowledged while disabled");

   gc_ack_a: assert property ( // RULE2
      @(posedge clk_link) disable iff (rst_link)
      (l_reg.st == i2c_gc_pkg::ST_ADDR && byte_done && scl_fall && !abort_l
       && match_gc && wr_ready)
      |=> (sda_oe && l_reg.gc && l_reg.st == i2c_gc_pkg::ST_ACK)
   ) else $error("enabled broadcast not acknowledged");

   rx_only_a: assert property ( // RULE3
      @(posedge clk_link) disable iff (rst_link)
      (l_reg.st == i2c_gc_pkg::ST_DATA) |-> !sda_oe
   ) else $error("slave drove data line during data byte");

   data_tag_a: assert property ( // RULE6
      @(posedge clk_link) disable iff (rst_link)
      (wr_valid && l_reg.st == i2c_gc_pkg::ST_DATA)
      |-> (!wr_data[i2c_gc_pkg::TAG_POS] && wr_data[7:0] == l_reg.shift)
   ) else $error("data byte altered or tagged as address");

   abort_idle_a: assert property ( // RULE9
      @(posedge clk_link) disable iff (rst_link)
      abort_l |=> (l_reg.st == i2c_gc_pkg::ST_IDLE && !sda_oe && !scl_oe)
   ) else $error("transfer kept running in power down");

   stretch_a: assert property (
      @(posedge clk_link) disable iff (rst_link)
      scl_oe |-> (byte_done && l_reg.st != i2c_gc_pkg::ST_ACK)
   ) else $error("clock held low outside a full byte");

   addr_flag_a: assert property ( // RULE4
      @(posedge clk_sys) disable iff (sys_rst)
      (rd_valid && rd_ready && rd_data[i2c_gc_pkg::TAG_POS])
      |=> (addressed_as_slave_flag && data_ready)
   ) else $error("address match did not raise flag");

   data_load_a: assert property ( // RULE5 RULE7
      @(posedge clk_sys) disable iff (sys_rst)
      (rd_valid && rd_ready)
      |=> (bus_data_register == $past(rd_data[i2c_gc_pkg::DATA_W-1:0]))
   ) else $error("received byte not in data register");

   stop_hold_a: assert property ( // RULE10
      @(posedge clk_sys) disable iff (sys_rst)
      stop_mode |=> ($stable(bus_data_register) && $stable(addressed_as_slave_flag)
                     && $stable(data_ready))
   ) else $error("registers changed in stop mode");

   one_irq_a: assert property ( // RULE11
      @(posedge clk_sys) disable iff (sys_rst)
      irq == (data_ready || addressed_as_slave_flag)
   ) else $error("interrupt line disagrees with its sources");

   gc_ack_c: cover property (
      @(posedge clk_link) disable iff (rst_link)
      wr_valid && l_reg.st == i2c_gc_pkg::ST_ADDR && match_gc
   );

   own_ack_c: cover property (
      @(posedge clk_link) disable iff (rst_link)
      wr_valid && l_reg.st == i2c_gc_pkg::ST_ADDR && !match_gc && match_own
   );

   stretch_c: cover property (
      @(posedge clk_link) disable iff (rst_link)
      scl_oe && !wr_ready
   );

   abort_c: cover property (
      @(posedge clk_link) disable iff (rst_link)
      abort_l && l_reg.st == i2c_gc_pkg::ST_DATA
   );

endmodule

// [i2c_general_call_power_modes_tb.sv]
// self-checking bench of the general call receiver
`timescale 1ns/1ps
module i2c_general_call_power_modes_tb;
   // ---------------------------------------------
   // clocks, stimulus, instances
   // ---------------------------------------------
   logic clk_sys = 1'b0;
   logic clk_link = 1'b0;
   logic sys_rst = 1'b1;
   logic general_call_enable = 1'b0;
   logic [i2c_gc_pkg::ADDR_W-1:0] own_address = 7'h2D;
   logic wait_mode = 1'b0;
   logic wait_power_down = 1'b0;
   logic stop_mode = 1'b0;
   logic data_read = 1'b0;
   logic flag_clear = 1'b0;
   logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
   logic [i2c_gc_pkg::DATA_W-1:0] bus_data_register;
   logic data_ready, addressed_as_slave_flag, irq, conflict, ack;
   int n_errors = 0;
   int n_tests = 0;

   always #5 clk_sys = ~clk_sys;
   initial begin
      #3.3;
      forever #7.5 clk_link = ~clk_link;
   end

   i2c_general_call_power_modes i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .clk_link(clk_link), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .general_call_enable(general_call_enable), .own_address(own_address),
      .wait_mode(wait_mode), .wait_power_down(wait_power_down), .stop_mode(stop_mode),
      .data_read(data_read), .flag_clear(flag_clear), .bus_data_register(bus_data_register),
      .data_ready(data_ready), .addressed_as_slave_flag(addressed_as_slave_flag), .irq(irq));

   i2c_master_model i_master (.scl_oe(scl_oe), .scl_out(scl_out), .sda_oe(sda_oe),
      .sda_out(sda_out), .scl_line(scl_in), .sda_line(sda_in), .conflict(conflict));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic strobe(input logic rd, input logic clr);
      @(negedge clk_sys);
      data_read = rd;
      flag_clear = clr;
      @(negedge clk_sys);
      data_read = 1'b0;
      flag_clear = 1'b0;
      @(negedge clk_sys);
   endtask

   task automatic send(input logic [7:0] b, input logic exp_ack);
      i_master.send_byte(b, ack);
      check("ack", ack, exp_ack);
   endtask

   task automatic got(input logic [7:0] exp, input logic last);
      int i;
      i = 0;
      while (data_ready !== 1'b1 && i < 400) begin
         @(negedge clk_sys);
         i++;
      end
      check("ready", data_ready, 1'b1);
      check("data", bus_data_register, exp);
      strobe(1'b1, 1'b0);
      if (last) check("ready", data_ready, 1'b0);
   endtask

   task automatic set_in(input logic gce, input logic wm, input logic wpd, input logic sm);
      @(negedge clk_sys);
      general_call_enable = gce;
      wait_mode = wm;
      wait_power_down = wpd;
      stop_mode = sm;
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_broadcast;
      set_in(1'b1, 1'b0, 1'b0, 1'b0);
      i_master.bus_start();
      send(8'h00, 1'b1);
      check("data", bus_data_register, 8'h00);
      check("ready", data_ready, 1'b1);
      check("flag", addressed_as_slave_flag, 1'b1);
      check("irq", irq, 1'b1);
      send(8'h5A, 1'b1);
      got(8'h00, 1'b0);
      got(8'h5A, 1'b1);
      strobe(1'b0, 1'b1);
      check("irq", irq, 1'b0);
      set_in(1'b0, 1'b0, 1'b0, 1'b0);
      send(8'hC4, 1'b0);
      i_master.bus_stop();
      check("ready", data_ready, 1'b0);
      $display("broadcast test done");
   endtask

   task automatic t_disabled;
      i_master.bus_start();
      send(8'h00, 1'b0);
      send(8'h33, 1'b0);
      i_master.bus_stop();
      i_master.bus_start();
      send({own_address, 1'b1}, 1'b0);
      i_master.bus_stop();
      check("ready", data_ready, 1'b0);
      check("flag", addressed_as_slave_flag, 1'b0);
      i_master.bus_start();
      send({own_address, 1'b0}, 1'b1);
      send(8'hC3, 1'b1);
      i_master.bus_stop();
      got({own_address, 1'b0}, 1'b0);
      check("flag", addressed_as_slave_flag, 1'b1);
      got(8'hC3, 1'b1);
      strobe(1'b0, 1'b1);
      $display("disabled and own address test done");
   endtask

   task automatic t_wait;
      set_in(1'b1, 1'b1, 1'b0, 1'b0);
      i_master.bus_start();
      send(8'h00, 1'b1);
      i_master.bus_stop();
      got(8'h00, 1'b1);
      strobe(1'b0, 1'b1);
      set_in(1'b1, 1'b0, 1'b1, 1'b0);
      i_master.bus_start();
      send(8'h00, 1'b1);
      fork
         i_master.send_byte(8'h77, ack);
         begin
            repeat (40) @(negedge clk_sys);
            wait_mode = 1'b1;
         end
      join
      check("ack", ack, 1'b0);
      i_master.bus_stop();
      set_in(1'b1, 1'b0, 1'b0, 1'b0);
      got(8'h00, 1'b1);
      strobe(1'b0, 1'b1);
      $display("wait mode test done");
   endtask

   task automatic t_stop;
      i_master.bus_start();
      send(8'h00, 1'b1);
      send(8'h96, 1'b1);
      i_master.bus_stop();
      set_in(1'b1, 1'b0, 1'b0, 1'b1);
      strobe(1'b1, 1'b1);
      check("data", bus_data_register, 8'h00);
      check("ready", data_ready, 1'b1);
      check("flag", addressed_as_slave_flag, 1'b1);
      i_master.bus_start();
      send(8'h00, 1'b0);
      i_master.bus_stop();
      set_in(1'b1, 1'b0, 1'b0, 1'b0);
      got(8'h00, 1'b0);
      got(8'h96, 1'b1);
      strobe(1'b0, 1'b1);
      $display("stop mode test done");
   endtask

   task automatic t_fifo;
      i_master.bus_start();
      send(8'h00, 1'b1);
      for (int k = 1; k <= i2c_gc_pkg::FIFO_DEPTH; k++) send(8'(k + 16), 1'b1);
      fork
         i_master.send_byte(8'hE9, ack);
         begin
            repeat (300) @(negedge clk_sys);
            check("scl_oe", scl_oe, 1'b1);
            got(8'h00, 1'b0);
            for (int k = 1; k <= i2c_gc_pkg::FIFO_DEPTH; k++) got(8'(k + 16), 1'b0);
            got(8'hE9, 1'b1);
         end
      join
      check("ack", ack, 1'b1);
      i_master.bus_stop();
      $display("buffer test done");
   endtask

   // ---------------------------------------------
   // sequence and verdict
   // ---------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (10) @(negedge clk_sys);
      check("irq", irq, 1'b0);
      t_broadcast();
      t_disabled();
      t_wait();
      t_stop();
      t_fifo();
      check("conflict", conflict, 1'b0);
      report_and_stop();
   end

   initial begin
      #500000;
      n_errors++;
      $display("ERROR watchdog expected finish seen timeout");
      report_and_stop();
   end
endmodule

// [i2c_master_model.sv]
// bus master model that broadcasts to and addresses the receiver
`timescale 1ns/1ps
module i2c_master_model #(
   parameter int HALF_NS = 100
) (
   input wire logic scl_oe,
   input wire logic scl_out,
   input wire logic sda_oe,
   input wire logic sda_out,
   output logic scl_line,
   output logic sda_line,
   output logic conflict
);
   // ---------------------------------------------
   // open drain wires with pull-ups
   // ---------------------------------------------
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;
   logic in_bits = 1'b0;

   assign scl_line = ~(scl_low | (scl_oe & ~scl_out));
   assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

   // receiver pulling data while master sends bits
   initial conflict = 1'b0;
   always @(posedge scl_line) begin
      if (in_bits && sda_line !== ~sda_low) conflict = 1'b1;
   end

   // ---------------------------------------------
   // bus conditions
   // ---------------------------------------------
   task automatic bus_start;
      sda_low = 1'b1;
      #HALF_NS;
      scl_low = 1'b1;
      #HALF_NS;
   endtask

   task automatic bus_stop;
      #20;
      sda_low = 1'b1;
      #HALF_NS;
      scl_low = 1'b0;
      wait (scl_line === 1'b1);
      #HALF_NS;
      sda_low = 1'b0;
      #HALF_NS;
   endtask

   // waits out clock stretching
   task automatic clock_pulse;
      #HALF_NS;
      scl_low = 1'b0;
      wait (scl_line === 1'b1);
      #HALF_NS;
   endtask

   // msb first, data moves only while clock low
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #20;
         sda_low = ~b[i];
         in_bits = 1'b1;
         clock_pulse();
         scl_low = 1'b1;
         in_bits = 1'b0;
      end
      #20;
      sda_low = 1'b0;
      clock_pulse();
      ack = ~sda_line;
      scl_low = 1'b1;
   endtask
endmodule
